/* File: inc/fpsc_pkg.sv */
// Package of the fan PWM speed controller: register map, field layout,
// reset values, timing counts and the structs that carry configuration.
// Assumes a single 20 MHz clock and a plain byte-addressed register port.
package fpsc_pkg;

    localparam int NFAN = 4;
    localparam int NGP = 2;

    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FFREQ = 8'h04;
    localparam logic [7:0] A_SHUT = 8'h08;
    localparam logic [7:0] A_ISTAT = 8'h0c;
    localparam logic [7:0] A_ICLR = 8'h10;
    localparam logic [7:0] A_IEN = 8'h14;
    localparam logic [7:0] A_FSTAT = 8'h18;
    localparam logic [7:0] A_GP_BASE = 8'h20;
    localparam logic [7:0] A_FAN_BASE = 8'h40;
    localparam logic [7:0] A_FAN_END = 8'hc0;
    // Offsets inside one fan's 32-byte group
    localparam logic [4:0] F_SPEED = 5'h00;
    localparam logic [4:0] F_DUTY = 5'h04;
    localparam logic [4:0] F_RATE = 5'h08;
    localparam logic [4:0] F_LIMIT = 5'h0c;
    localparam logic [4:0] F_PPR = 5'h10;
    localparam logic [4:0] F_FINC = 5'h14;
    localparam logic [4:0] F_TACH = 5'h18;
    localparam logic [4:0] F_CUR = 5'h1c;
    // Offsets inside one general-purpose PWM's 16-byte group
    localparam logic [3:0] G_DUTY = 4'h0;
    localparam logic [3:0] G_FREQ = 4'h4;
    localparam logic [3:0] G_PHASE = 4'h8;

    // Field positions
    localparam int C_VAR_BIT = 0;
    localparam int C_IMM_BIT = 1;
    localparam int S_EXTRA_LSB = 4;
    localparam int D_ON_LSB = 0;
    localparam int D_OFF_LSB = 8;
    localparam int D_MAX_LSB = 16;
    localparam int ST_SHUT_BIT = 4;
    localparam int ST_ANY_BIT = 5;

    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [31:0] FFREQ_RST = 32'h0147ae14;
    localparam logic [6:0] ON_RST = 7'h5a;
    localparam logic [6:0] OFF_RST = 7'h0a;
    localparam logic [6:0] MAX_RST = 7'h5f;
    localparam logic [16:0] RATE_RST = 17'h00fa0;
    localparam logic [19:0] LIMIT_RST = 20'h04e20;
    localparam logic [3:0] PPR_RST = 4'h2;

    // Scaling
    localparam logic [6:0] FULL_PCT = 7'h64;
    localparam logic [13:0] PCT_SCALE = 14'h0064;
    localparam logic [13:0] FULL_DUTY = 14'h2710;
    localparam logic [19:0] STEP_UNIT = 20'hf4240;
    localparam logic [31:0] RPM_SCALE = 32'h00001770;

    // Timing
    localparam int CLK_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0] MS_PER_S = 10'h3e8;
    localparam logic [2:0] FAULT_S = 3'h5;

    typedef struct packed {
        logic [6:0] speed;
        logic [6:0] on;
        logic [6:0] off;
        logic [6:0] max;
        logic [16:0] rate;
        logic [19:0] limit;
        logic [3:0] ppr;
        logic [6:0] finc;
    } fpsc_fan_cfg_type;

    typedef struct packed {
        logic [13:0] duty;
        logic [31:0] freq;
        logic [15:0] phase;
    } fpsc_pwm_cfg_type;

    localparam fpsc_fan_cfg_type FAN_CFG_RST = '{speed: 7'h00, on: ON_RST, off: OFF_RST,
        max: MAX_RST, rate: RATE_RST, limit: LIMIT_RST, ppr: PPR_RST, finc: 7'h00};

endpackage

/* File: rtl/fpsc_pwm_gen.sv */
// One PWM channel: phase accumulator, phase offset and duty compare.
// Assumes the config struct is held steady by the caller between commands.
`timescale 1ns/10ps
module fpsc_pwm_gen
    import fpsc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input fpsc_pwm_cfg_type cfg,
    output logic pwm
);

    logic [31:0] acc_q;
    logic [15:0] pos;
    logic [29:0] pos_scaled;
    logic pwm_q;

    // programmable frequency
    // Frequency is the accumulator step; top rate is limited by the clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            acc_q <= 32'h0;
        else
            acc_q <= acc_q + cfg.freq;
    end

    // fixed duty phase
    // Position in the period, scaled to 0.01 percent steps
    assign pos = acc_q[31:16] + cfg.phase;
    assign pos_scaled = 30'(pos) * 30'(16'h2710);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pwm_q <= 1'b0;
        else
            pwm_q <= (pos_scaled[29:16] < cfg.duty);
    end

    assign pwm = pwm_q;

    a_pwm_zero_off: assert property (@(posedge clk) disable iff (!nrst)
        cfg.duty == 14'h0 |=> !pwm_q)
        else $error("pwm high with zero duty");
    a_pwm_full_on: assert property (@(posedge clk) disable iff (!nrst)
        cfg.duty == FULL_DUTY |=> pwm_q)
        else $error("pwm low with full duty");

endmodule

/* File: rtl/fpsc_top.sv */
// Fan PWM speed controller with tach fault detection and general PWMs.
// Assumes one 20 MHz clock, tach pins asynchronous, plain register port.
//
// How it works
// - In percent-of-full-speed mode each fan's PWM duty follows its commanded, ramped speed; otherwise a running fan gets the maximum duty.
// - In percent-of-full-speed mode a speed of 100 gives the maximum duty.
// - A turn-on duty setting gives the duty where the fan starts.
// - A running fan never gets a duty below the turn-off setting.
// - A maximum duty setting gives the duty of the highest fan speed.
// - Speed moves toward its target no faster than the set percent per second.
// - With immediate apply set, a new rate acts at once even mid-ramp.
// - Five seconds below the speed limit flags a fan fault and the alert.
// - When enabled, a failed fan plus the set number of others shuts down.
// - A failing fan adds its fault increase to every other fan, capped at 100.
// - A non-zero fault increase is cleared to zero once it has been applied.
// - General PWMs keep duty, frequency and phase until a new write.
// - Fan PWM frequency is programmable.
// - Tach pulses convert to speed through a pulses-per-revolution setting.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module fpsc_top
    import fpsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [NFAN-1:0] tach,
    output logic [NFAN-1:0] fan_pwm,
    output logic [NGP-1:0] gp_pwm,
    output logic fan_alert_n,
    output logic system_shutdown,
    output logic irq
);

    logic [1:0] ctrl_q;
    logic [31:0] ffreq_q;
    logic [NFAN-1:0] shut_en_q;
    logic [2:0] shut_extra_q;
    logic [4:0] ien_q;
    logic [4:0] istat_q;
    fpsc_fan_cfg_type fan_cfg_q [NFAN];
    fpsc_pwm_cfg_type gp_cfg_q [NGP];
    fpsc_pwm_cfg_type fan_pwm_cfg [NFAN];
    logic [NFAN-1:0] tach_s1_q, tach_s2_q, tach_s3_q;
    logic [15:0] tick_cnt_q;
    logic [9:0] ms_cnt_q;
    logic tick, sec;
    logic [15:0] pulse_cnt_q [NFAN];
    logic [15:0] tach_q [NFAN];
    logic [2:0] below_cnt_q [NFAN];
    logic [NFAN-1:0] below, fault, fail_evt, run;
    logic [6:0] boost_q [NFAN];
    logic [6:0] tgt [NFAN];
    logic [6:0] cur_q [NFAN];
    logic [19:0] racc_q [NFAN];
    logic [16:0] act_rate_q [NFAN];
    logic [13:0] duty [NFAN];
    logic shutdown_q, sd_cond;
    logic [2:0] nfail;
    logic [31:0] rdata_q, rdata_d;
    logic fan_hit, gp_hit;
    logic [7:0] rel;
    logic [1:0] fidx;
    logic [4:0] foff;
    logic gidx;

    // Register address decode
    assign fan_hit = (addr >= A_FAN_BASE) && (addr < A_FAN_END);
    assign rel = addr - A_FAN_BASE;
    assign fidx = rel[6:5];
    assign foff = addr[4:0];
    assign gp_hit = (addr >= A_GP_BASE) && (addr < A_FAN_BASE);
    assign gidx = addr[4];

    // Global control registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= CTRL_RST;
            ffreq_q <= FFREQ_RST;
            shut_en_q <= '0;
            shut_extra_q <= 3'h0;
            ien_q <= 5'h0;
        end
        else if (wr)
        begin
            case (addr)
                A_CTRL: ctrl_q <= wdata[1:0];
                A_FFREQ: ffreq_q <= wdata;
                A_SHUT:
                begin
                    shut_en_q <= wdata[NFAN-1:0];
                    shut_extra_q <= wdata[S_EXTRA_LSB +: 3];
                end
                A_IEN: ien_q <= wdata[4:0];
                default: ;
            endcase
        end
    end

    // gp settings held
    // Only a write to a channel's own word changes it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int g = 0; g < NGP; g++)
                gp_cfg_q[g] <= '0;
        end
        else if (wr && gp_hit)
        begin
            case (addr[3:0])
                G_DUTY: gp_cfg_q[gidx].duty <= wdata[13:0];
                G_FREQ: gp_cfg_q[gidx].freq <= wdata;
                G_PHASE: gp_cfg_q[gidx].phase <= wdata[15:0];
                default: ;
            endcase
        end
    end

    // Fan settings; a software write wins over the hardware clear
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NFAN; i++)
                fan_cfg_q[i] <= FAN_CFG_RST;
        end
        else
        begin
            for (int i = 0; i < NFAN; i++)
                if (fail_evt[i])
                    fan_cfg_q[i].finc <= 7'h0;
            if (wr && fan_hit)
            begin
                case (foff)
                    F_SPEED: fan_cfg_q[fidx].speed <= wdata[6:0];
                    F_DUTY:
                    begin
                        fan_cfg_q[fidx].on <= wdata[D_ON_LSB +: 7];
                        fan_cfg_q[fidx].off <= wdata[D_OFF_LSB +: 7];
                        fan_cfg_q[fidx].max <= wdata[D_MAX_LSB +: 7];
                    end
                    F_RATE: fan_cfg_q[fidx].rate <= wdata[16:0];
                    F_LIMIT: fan_cfg_q[fidx].limit <= wdata[19:0];
                    F_PPR: fan_cfg_q[fidx].ppr <= wdata[3:0];
                    F_FINC: fan_cfg_q[fidx].finc <= wdata[6:0];
                    default: ;
                endcase
            end
        end
    end

    // Tach pins: three stages, rising edge when stage two is high and stage three still low
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tach_s1_q <= '0;
            tach_s2_q <= '0;
            tach_s3_q <= '0;
        end
        else
        begin
            tach_s1_q <= tach;
            tach_s2_q <= tach_s1_q;
            tach_s3_q <= tach_s2_q;
        end
    end

    // Millisecond tick and one-second mark
    assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
    assign sec = tick && (ms_cnt_q == MS_PER_S - 10'h1);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= 16'h0;
            ms_cnt_q <= 10'h0;
        end
        else
        begin
            tick_cnt_q <= tick ? 16'h0 : tick_cnt_q + 16'h1;
            if (tick)
                ms_cnt_q <= sec ? 10'h0 : ms_cnt_q + 10'h1;
        end
    end

    // Pulses per second, compared in units of 0.01 RPM
    always_comb
    begin
        for (int i = 0; i < NFAN; i++)
        begin
            run[i] = (cur_q[i] != 7'h0);
            below[i] = 32'(pulse_cnt_q[i]) * RPM_SCALE
                < 32'(fan_cfg_q[i].limit) * 32'(fan_cfg_q[i].ppr);
            fault[i] = (below_cnt_q[i] == FAULT_S);
            fail_evt[i] = sec && below[i] && run[i] && (below_cnt_q[i] == FAULT_S - 3'h1);
        end
    end

    // Per-second tach window and consecutive-low count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NFAN; i++)
            begin
                pulse_cnt_q[i] <= 16'h0;
                tach_q[i] <= 16'h0;
                below_cnt_q[i] <= 3'h0;
            end
        end
        else
        begin
            for (int i = 0; i < NFAN; i++)
            begin
                if (sec)
                begin
                    pulse_cnt_q[i] <= 16'h0;
                    tach_q[i] <= pulse_cnt_q[i];
                    if (!below[i] || !run[i])
                        below_cnt_q[i] <= 3'h0;
                    else if (below_cnt_q[i] != FAULT_S)
                        below_cnt_q[i] <= below_cnt_q[i] + 3'h1;
                end
                else if (tach_s2_q[i] && !tach_s3_q[i] && pulse_cnt_q[i] != 16'hffff)
                    pulse_cnt_q[i] <= pulse_cnt_q[i] + 16'h1;
            end
        end
    end

    // boost other fans
    // Boosts sum over fans failing together, each capped at full speed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NFAN; i++)
                boost_q[i] <= 7'h0;
        end
        else
        begin
            for (int i = 0; i < NFAN; i++)
            begin
                logic [9:0] sum;
                sum = 10'(boost_q[i]);
                for (int j = 0; j < NFAN; j++)
                    if (fail_evt[j] && j != i)
                        sum = sum + 10'(fan_cfg_q[j].finc);
                boost_q[i] <= (sum > 10'(FULL_PCT)) ? FULL_PCT : sum[6:0];
            end
        end
    end

    // Target speed, capped at full speed
    always_comb
    begin
        for (int i = 0; i < NFAN; i++)
        begin
            logic [7:0] t;
            t = 8'(fan_cfg_q[i].speed) + 8'(boost_q[i]);
            tgt[i] = (t > 8'(FULL_PCT)) ? FULL_PCT : t[6:0];
        end
    end

    // immediate rate apply
    // Otherwise a new rate waits for the next speed command or a fan at its target speed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NFAN; i++)
                act_rate_q[i] <= RATE_RST;
        end
        else
        begin
            for (int i = 0; i < NFAN; i++)
            begin
                if (wr && fan_hit && fidx == 2'(i) && foff == F_RATE && ctrl_q[C_IMM_BIT])
                    act_rate_q[i] <= wdata[16:0];
                else if (wr && fan_hit && fidx == 2'(i) && foff == F_SPEED)
                    act_rate_q[i] <= fan_cfg_q[i].rate;
                else if (cur_q[i] == tgt[i])
                    act_rate_q[i] <= fan_cfg_q[i].rate;
            end
        end
    end

    // rate-limited ramp
    // Rate in 0.001 %/s equals micro-percent per ms; one step per tick at most
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NFAN; i++)
            begin
                cur_q[i] <= 7'h0;
                racc_q[i] <= 20'h0;
            end
        end
        else
        begin
            for (int i = 0; i < NFAN; i++)
            begin
                if (cur_q[i] == tgt[i])
                    racc_q[i] <= 20'h0;
                else if (tick)
                begin
                    // Sum kept one bit wider; a fast rate near a step would wrap
                    if (21'(racc_q[i]) + 21'(act_rate_q[i]) >= 21'(STEP_UNIT))
                    begin
                        racc_q[i] <= 20'(21'(racc_q[i]) + 21'(act_rate_q[i]) - 21'(STEP_UNIT));
                        cur_q[i] <= (cur_q[i] < tgt[i]) ? cur_q[i] + 7'h1 : cur_q[i] - 7'h1;
                    end
                    else
                        racc_q[i] <= racc_q[i] + 20'(act_rate_q[i]);
                end
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NFAN; i++)
        begin
            logic [6:0] span;
            logic [13:0] lin;
            span = (fan_cfg_q[i].max > fan_cfg_q[i].on) ? fan_cfg_q[i].max - fan_cfg_q[i].on : 7'h0;
            lin = 14'(fan_cfg_q[i].on * PCT_SCALE) + 14'(span) * 14'(cur_q[i]);
            if (!ctrl_q[C_VAR_BIT])
                lin = 14'(fan_cfg_q[i].max * PCT_SCALE);
            if (lin < 14'(fan_cfg_q[i].off * PCT_SCALE))
                lin = 14'(fan_cfg_q[i].off * PCT_SCALE);
            if (lin > FULL_DUTY)
                lin = FULL_DUTY;
            duty[i] = run[i] ? lin : 14'h0;
            fan_pwm_cfg[i] = '{duty: duty[i], freq: ffreq_q, phase: 16'h0};
        end
    end

    always_comb
    begin
        nfail = 3'h0;
        for (int i = 0; i < NFAN; i++)
            nfail = nfail + 3'(fault[i]);
    end
    assign sd_cond = (|(fault & shut_en_q)) && (4'(nfail) >= 4'(shut_extra_q) + 4'h1);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            shutdown_q <= 1'b0;
        else if (sd_cond)
            shutdown_q <= 1'b1;
    end

    // Sticky event status; set wins over a same-cycle clear
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            istat_q <= 5'h0;
        else
            istat_q <= (istat_q & ~((wr && addr == A_ICLR) ? wdata[4:0] : 5'h0))
                | {sd_cond && !shutdown_q, fail_evt};
    end

    // Read mux; unmapped and write-only words read zero
    always_comb
    begin
        rdata_d = 32'h0;
        if (fan_hit)
        begin
            case (foff)
                F_SPEED: rdata_d = 32'(fan_cfg_q[fidx].speed);
                F_DUTY: rdata_d = {9'h0, fan_cfg_q[fidx].max, 1'b0, fan_cfg_q[fidx].off,
                    1'b0, fan_cfg_q[fidx].on};
                F_RATE: rdata_d = 32'(fan_cfg_q[fidx].rate);
                F_LIMIT: rdata_d = 32'(fan_cfg_q[fidx].limit);
                F_PPR: rdata_d = 32'(fan_cfg_q[fidx].ppr);
                F_FINC: rdata_d = 32'(fan_cfg_q[fidx].finc);
                F_TACH: rdata_d = 32'(tach_q[fidx]);
                F_CUR: rdata_d = 32'(cur_q[fidx]);
                default: rdata_d = 32'h0;
            endcase
        end
        else if (gp_hit)
        begin
            case (addr[3:0])
                G_DUTY: rdata_d = 32'(gp_cfg_q[gidx].duty);
                G_FREQ: rdata_d = gp_cfg_q[gidx].freq;
                G_PHASE: rdata_d = 32'(gp_cfg_q[gidx].phase);
                default: rdata_d = 32'h0;
            endcase
        end
        else
        begin
            case (addr)
                A_CTRL: rdata_d = 32'(ctrl_q);
                A_FFREQ: rdata_d = ffreq_q;
                A_SHUT: rdata_d = {25'h0, shut_extra_q, shut_en_q};
                A_ISTAT: rdata_d = 32'(istat_q);
                A_IEN: rdata_d = 32'(ien_q);
                A_FSTAT: rdata_d = {26'h0, |fault, shutdown_q, fault};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= 32'h0;
        else if (rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= 32'h0;
    end

    // PWM channels: fans first, then general-purpose outputs
    for (genvar i = 0; i < NFAN; i++)
    begin : g_fan
        fpsc_pwm_gen u_pwm (.clk(clk), .nrst(nrst), .cfg(fan_pwm_cfg[i]), .pwm(fan_pwm[i]));
    end
    for (genvar g = 0; g < NGP; g++)
    begin : g_gp
        fpsc_pwm_gen u_pwm (.clk(clk), .nrst(nrst), .cfg(gp_cfg_q[g]), .pwm(gp_pwm[g]));
    end

    assign rdata = rdata_q;
    assign irq = |(istat_q & ien_q);
    // alert stays low until the fault bits are cleared
    assign fan_alert_n = ~(|istat_q[NFAN-1:0]);
    assign system_shutdown = shutdown_q;

    a_fault_alert_set: assert property (@(posedge clk) disable iff (!nrst)
        fail_evt[1] |=> istat_q[1] && !fan_alert_n)
        else $error("fan fault did not raise alert");
    a_duty_off_floor: assert property (@(posedge clk) disable iff (!nrst)
        run[0] |-> duty[0] >= 14'(fan_cfg_q[0].off * PCT_SCALE))
        else $error("duty below turn-off floor");
    a_full_speed_max: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_q[C_VAR_BIT] && cur_q[0] == FULL_PCT && fan_cfg_q[0].max >= fan_cfg_q[0].on
        && fan_cfg_q[0].max >= fan_cfg_q[0].off && fan_cfg_q[0].max <= FULL_PCT
        |-> duty[0] == 14'(fan_cfg_q[0].max * PCT_SCALE))
        else $error("full speed not at max duty");
    a_ramp_step_hold: assert property (@(posedge clk) disable iff (!nrst)
        !tick |=> cur_q[0] == $past(cur_q[0]))
        else $error("speed moved between ticks");
    a_stop_zero_duty: assert property (@(posedge clk) disable iff (!nrst)
        cur_q[1] == 7'h0 |-> duty[1] == 14'h0)
        else $error("stopped fan has duty");
    a_finc_cleared: assert property (@(posedge clk) disable iff (!nrst)
        fail_evt[1] && !wr |=> fan_cfg_q[1].finc == 7'h0)
        else $error("fault increase not cleared");
    a_boost_capped: assert property (@(posedge clk) disable iff (!nrst)
        fail_evt == 4'b0010 && fan_cfg_q[1].finc != 7'h0
        |=> boost_q[0] == ((8'($past(boost_q[0])) + 8'($past(fan_cfg_q[1].finc)) > 8'(FULL_PCT))
        ? FULL_PCT : 7'($past(boost_q[0]) + $past(fan_cfg_q[1].finc))))
        else $error("boost wrong or uncapped");
    a_shutdown_hold: assert property (@(posedge clk) disable iff (!nrst)
        sd_cond |=> system_shutdown [*3])
        else $error("shutdown not asserted and held");
    a_gp_cfg_stable: assert property (@(posedge clk) disable iff (!nrst)
        !(wr && gp_hit) |=> gp_cfg_q[0] == $past(gp_cfg_q[0]))
        else $error("gp pwm changed without a write");

    c_fan_fail: cover property (@(posedge clk) disable iff (!nrst) fail_evt[1]);
    c_shutdown: cover property (@(posedge clk) disable iff (!nrst) $rose(shutdown_q));
    c_full_speed: cover property (@(posedge clk) disable iff (!nrst) cur_q[0] == FULL_PCT);

endmodule

/* File: dv/fpsc_fan_model.sv */
// Fan model: tach pulses while spinning, quiet tach when stalled.
// Assumes the bench sets spin per fan; tach idles low.
`timescale 1ns/10ps
module fpsc_fan_model
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic spin,
    output logic tach
);
    logic [3:0] cnt_q;
    // One pulse per 16 cycles, fast enough to clear the reset speed limit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= 4'h0;
        else if (spin)
            cnt_q <= cnt_q + 4'h1;
    end
    assign tach = spin && cnt_q[3];
endmodule

/* File: dv/fpsc_top_tb.sv */
// Bench of the fan controller: reset rows, ramp, duty, fault and alert.
// Assumes 1 ms tick shortened to 4 cycles, so a second is 4000 cycles.
`timescale 1ns/10ps
module fpsc_top_tb
    import fpsc_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] spin = 4'hf;
    logic [31:0] rdata;
    logic [NFAN-1:0] tach;
    logic [NFAN-1:0] fan_pwm;
    logic [NGP-1:0] gp_pwm;
    logic fan_alert_n;
    logic system_shutdown;
    logic irq;
    int err_count = 0;
    int n_checks = 0;
    int hi = 0;
    logic [7:0] ra [8] = '{A_CTRL, A_FFREQ, 8'h44, 8'h48, 8'h4c, 8'h50, A_ICLR, 8'hfc};
    logic [31:0] rv [8] = '{32'(CTRL_RST), FFREQ_RST,
        {9'h0, MAX_RST, 1'b0, OFF_RST, 1'b0, ON_RST},
        32'(RATE_RST), 32'(LIMIT_RST), 32'(PPR_RST), 32'h0, 32'h0};

    initial
    begin
        forever #25 clk = ~clk;
    end

    fpsc_top #(.TICK_CYCLES(4)) dut_u (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tach(tach),
        .fan_pwm(fan_pwm), .gp_pwm(gp_pwm), .fan_alert_n(fan_alert_n),
        .system_shutdown(system_shutdown), .irq(irq));

    for (genvar i = 0; i < NFAN; i++)
    begin : g_fan
        fpsc_fan_model fan_u (.clk(clk), .nrst(nrst), .spin(spin[i]), .tach(tach[i]));
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // High cycles of one output over 4000 cycles, twenty PWM periods
    task automatic count_hi(input int ch, output int n);
        n = 0;
        repeat (4000)
        begin
            @(negedge clk);
            n += (ch < NFAN) ? int'(fan_pwm[ch]) : int'(gp_pwm[ch - NFAN]);
        end
    endtask

    // Polls under a bound; running out ends the run
    task automatic wait_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        for (int k = 0; k < 20000; k++)
        begin
            rreg(a, d);
            if (d === exp)
                break;
        end
        chk(nm, exp, d);
        if (d !== exp)
            tally_and_finish();
    endtask

    initial
    begin
        logic [31:0] d;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Reset rows, write-only and unmapped places read zero
        for (int i = 0; i < 8; i++)
        begin
            rreg(ra[i], d);
            chk("reset row", rv[i], d);
        end
        chk("alert idle", 32'h1, 32'(fan_alert_n));
        // General PWM 0 at half duty, PWM 1 never written
        wreg(8'h20, 32'h1388);
        wreg(8'h24, FFREQ_RST);
        // Slow rate first, then a fast one that must act mid-ramp
        wreg(A_CTRL, 32'h3);
        wreg(8'h48, 32'h1);
        wreg(8'h40, 32'h64);
        // Long enough that the reset rate would already have stepped
        repeat (1200) @(posedge clk);
        rreg(8'h5c, d);
        chk("slow ramp", 32'h0, d);
        wreg(8'h48, 32'h1ffff);
        wait_reg("ramp end", 8'h5c, 32'h64);
        // Full speed gives max duty, 95 percent; gp 0 half, gp 1 silent
        count_hi(0, hi);
        chk("full duty", 32'h1, 32'(hi >= 3794 && hi <= 3806));
        count_hi(NFAN, hi);
        chk("gp half duty", 32'h1, 32'(hi >= 1994 && hi <= 2006));
        count_hi(NFAN + 1, hi);
        chk("gp idle", 32'h0, 32'(hi));
        // Stall fan 1 with shutdown, fault increase and mask set
        spin <= 4'b1101;
        wreg(A_IEN, 32'h0);
        wreg(A_SHUT, 32'h2);
        wreg(8'h88, 32'h1ffff);
        wreg(8'h74, 32'h14);
        wreg(8'h60, 32'h32);
        wait_reg("fail status", A_ISTAT, 32'h12);
        @(negedge clk);
        chk("alert", 32'h0, 32'(fan_alert_n));
        chk("shutdown", 32'h1, 32'(system_shutdown));
        rreg(A_FSTAT, d);
        chk("fault live", 32'h32, d);
        rreg(8'h58, d);
        chk("tach count", 32'hfa, d);
        chk("irq masked", 32'h0, 32'(irq));
        wreg(A_IEN, 32'h1f);
        @(negedge clk);
        chk("irq on", 32'h1, 32'(irq));
        rreg(8'h74, d);
        chk("finc cleared", 32'h0, d);
        wait_reg("boosted fan", 8'h9c, 32'h14);
        rreg(8'h5c, d);
        chk("boost cap", 32'h64, d);
        // Fan 2 at 20 percent: interpolated, then max duty in simple mode
        count_hi(2, hi);
        chk("interp duty", 32'h1, 32'(hi >= 3634 && hi <= 3646));
        wreg(A_CTRL, 32'h2);
        count_hi(2, hi);
        chk("simple mode", 32'h1, 32'(hi >= 3794 && hi <= 3806));
        wreg(A_ICLR, 32'h1f);
        rreg(A_ISTAT, d);
        chk("cleared", 32'h0, d);
        chk("irq off", 32'h0, 32'(irq));
        chk("alert off", 32'h1, 32'(fan_alert_n));
        // Mid-run reset drops shutdown, speed and drive
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("reset shutdown", 32'h0, 32'(system_shutdown));
        chk("reset pwm", 32'h0, 32'(fan_pwm));
        rreg(8'h40, d);
        chk("reset speed", 32'h0, d);
        tally_and_finish();
    end
endmodule
